// ==== hw/kms_pkg.sv ====
package kms_pkg;
  localparam int NUM_ROWS = 5;
  localparam int NUM_COLS = 6;
  localparam int ROW_WORD_W = 40;
  localparam int REPORT_KEYS = 6;
  localparam int CLK_FREQ_HZ = 50000000;
  localparam int RELEASE_HOLDOFF = 6;
  localparam int SETTLE_NS = 20000;
  localparam int SETTLE_CYC = SETTLE_NS / 20;
  localparam int REPEAT_PERIOD_MS = 200;
  localparam int STUCK_TIMEOUT_S = 60;
  localparam int TS_W = 40;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h1;
  localparam logic [ADDR_W-1:0] RPT_CNT_OFS = 4'h2;
  localparam logic [ADDR_W-1:0] RPT_LIST_OFS = 4'h3;
  localparam logic [ADDR_W-1:0] MAP_ADDR_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] MAP_DATA_OFS = 4'h5;
  localparam logic [ADDR_W-1:0] SCAN_GO_OFS = 4'h6;
  localparam int CTRL_DELIVER_BIT = 0;
  localparam int CTRL_RPT_EN_BIT = 1;
  localparam int CTRL_STUCK_EN_BIT = 2;
  localparam int CTRL_FAST_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h1;
  typedef struct packed {
    logic [2:0] count;
    logic [REPORT_KEYS*8-1:0] codes;
  } kms_report_type;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_FULL = 5'b0_0010,
    ST_ROW = 5'b0_0100,
    ST_FILT = 5'b0_1000,
    ST_MAP = 5'b1_0000
  } kms_state_type;
endpackage

// ==== hw/kms_scanner.sv ====
`timescale 1ns/10ps
// How it works
// - Full scan drives all rows, records column hits
// - No column hit past the holdoff ends scan at once
// - Full scan waits 20us settle before sampling
// - Row scanning stops at the sixth clean full scan
// - Press found: drive one row at a time
// - Row scan samples only flagged columns
// - Wait 20us per row, store that row's sample at settle end
// - One state word per row, bit per column
// - Accept matrix stable twice and changed
// - Fast wake scan skips debounce filtering
// - Buffered entry released only when delivery set
// - Auto-repeat off by default, enable bit
// - Held repeat key re-reports every period
// - Stuck handling off by default, enable bit
// - Unchanged held state past timeout: deep sleep
// - Keep per-row jammed flags during filtering
// - Timestamp each update showing a press
// - Stuck sleep switches jammed rows' wake to low
// - Report count and first six codes
module kms_scanner #(
  parameter int REPEAT_CYC = kms_pkg::REPEAT_PERIOD_MS * (kms_pkg::CLK_FREQ_HZ / 1000),
  parameter longint STUCK_CYC = longint'(kms_pkg::STUCK_TIMEOUT_S) * kms_pkg::CLK_FREQ_HZ
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [kms_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [kms_pkg::NUM_COLS-1:0] col_i,
  output logic [kms_pkg::NUM_ROWS-1:0] row_o,
  output logic [kms_pkg::NUM_ROWS-1:0] row_oe_o,
  output logic update_o,
  output kms_pkg::kms_report_type key_report_o,
  output logic deep_sleep_o,
  output logic [kms_pkg::NUM_ROWS-1:0] wake_low_o
);
  localparam int NR = kms_pkg::NUM_ROWS;
  localparam int NC = kms_pkg::NUM_COLS;
  localparam int NK = NR * NC;
  typedef logic [kms_pkg::ROW_WORD_W-1:0] row_word_type;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and column synchroniser
  logic [NC-1:0] col_s1_r, col_s2_r;
  logic [3:0] ctrl_r;
  logic [2:0] rpt_cnt_r;
  logic [7:0] rpt_list_r [8];
  logic [7:0] key_code_map [NK];
  logic [4:0] map_addr_r;
  kms_pkg::kms_state_type state_r;
  logic [15:0] settle_r;
  logic [2:0] row_idx_r;
  logic [NC-1:0] col_hit_r;
  logic [2:0] release_cnt_r;
  row_word_type pressed_matrix_r [NR];
  row_word_type prev_matrix_r [NR];
  row_word_type accepted_r [NR];
  logic [NR-1:0] jammed_row_flags_r;
  logic [NK-1:0] flat_r;
  logic pend_r;
  logic [4:0] map_idx_r;
  kms_pkg::kms_report_type rep_r;
  logic [31:0] rpt_timer_r;
  logic [kms_pkg::TS_W-1:0] now_r, last_press_timestamp_r;
  logic [31:0] rdata_r;
  logic upd_r, sleep_r;
  logic [NR-1:0] row_r, wake_low_r;
  logic scan_go_r;

  always_ff @(posedge clk_i) begin
    col_s1_r <= col_i;
    col_s2_r <= col_s1_r;
  end

  // Host writes; key map is loaded through an address/data pair
  wire wr_ctrl = wr_i && (addr_i == kms_pkg::CTRL_OFS);
  wire wr_go = wr_i && (addr_i == kms_pkg::SCAN_GO_OFS);
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl_r <= kms_pkg::CTRL_RESET;
      rpt_cnt_r <= 3'h0;
      map_addr_r <= 5'h0_0;
    end else begin
      if (wr_ctrl) ctrl_r <= wdata_i[3:0];
      if (wr_i && addr_i == kms_pkg::RPT_CNT_OFS) rpt_cnt_r <= wdata_i[2:0];
      if (wr_i && addr_i == kms_pkg::RPT_LIST_OFS) rpt_list_r[wdata_i[10:8]] <= wdata_i[7:0];
      if (wr_i && addr_i == kms_pkg::MAP_ADDR_OFS) map_addr_r <= wdata_i[4:0];
      if (wr_i && addr_i == kms_pkg::MAP_DATA_OFS) key_code_map[map_addr_r] <= wdata_i[7:0];
    end
  end
  wire deliver = ctrl_r[kms_pkg::CTRL_DELIVER_BIT];
  wire rpt_en = ctrl_r[kms_pkg::CTRL_RPT_EN_BIT];
  wire stuck_en = ctrl_r[kms_pkg::CTRL_STUCK_EN_BIT];
  wire fast = ctrl_r[kms_pkg::CTRL_FAST_BIT];

  // Read mux; status shows state, pending entry and jam flags
  wire [31:0] status_w = {11'h000, jammed_row_flags_r, col_hit_r, sleep_r, pend_r,
    3'h0, state_r};
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) rdata_r <= 32'h0000_0000;
    else if (rd_i) begin
      case (addr_i)
        kms_pkg::CTRL_OFS: rdata_r <= {28'h000_0000, ctrl_r};
        kms_pkg::STATUS_OFS: rdata_r <= status_w;
        kms_pkg::RPT_CNT_OFS: rdata_r <= {29'h0000_0000, rpt_cnt_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else rdata_r <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan sequencer
  wire settled = (settle_r == 16'(kms_pkg::SETTLE_CYC - 1));
  wire [NC-1:0] col_act = col_s2_r; // Drive level high means pressed
  wire [NC-1:0] row_sample = col_act & col_hit_r;
  logic equal_prev, equal_acc, any_set;
  always_comb begin
    equal_prev = 1'b1;
    equal_acc = 1'b1;
    any_set = 1'b0;
    for (int r = 0; r < NR; r++) begin
      if (pressed_matrix_r[r] != prev_matrix_r[r]) equal_prev = 1'b0;
      if (pressed_matrix_r[r] != accepted_r[r]) equal_acc = 1'b0;
      if (pressed_matrix_r[r] != '0) any_set = 1'b1;
    end
  end
  // Fast wake bypasses the two-scan agreement
  wire accept = (fast || equal_prev) && !equal_acc;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_r <= kms_pkg::ST_IDLE;
      settle_r <= 16'h0000;
      row_idx_r <= 3'h0;
      col_hit_r <= '0;
      // Start saturated: no earlier press to hold off, so an idle scan ends at once
      release_cnt_r <= 3'(kms_pkg::RELEASE_HOLDOFF);
      row_r <= '0;
      scan_go_r <= 1'b0;
      for (int r = 0; r < NR; r++) begin
        pressed_matrix_r[r] <= '0;
        prev_matrix_r[r] <= '0;
        accepted_r[r] <= '0;
      end
      pend_r <= 1'b0;
      flat_r <= '0;
    end else begin
      scan_go_r <= wr_go;
      case (state_r)
        kms_pkg::ST_IDLE: begin
          if (scan_go_r) begin
            row_r <= '1;
            settle_r <= 16'h0000;
            state_r <= kms_pkg::ST_FULL;
          end
        end
        kms_pkg::ST_FULL: begin
          settle_r <= settle_r + 16'h0001;
          if (settled) begin
            col_hit_r <= col_act;
            row_r <= '0;
            if (col_act != '0) release_cnt_r <= 3'h0;
            else if (release_cnt_r != 3'(kms_pkg::RELEASE_HOLDOFF)) begin
              release_cnt_r <= release_cnt_r + 3'h1;
            end
            if (col_act == '0 &&
                release_cnt_r >= 3'(kms_pkg::RELEASE_HOLDOFF - 1)) begin
              state_r <= kms_pkg::ST_IDLE;
              for (int r = 0; r < NR; r++) pressed_matrix_r[r] <= '0;
            end else begin
              row_idx_r <= 3'h0;
              settle_r <= 16'h0000;
              row_r <= 5'h01;
              state_r <= kms_pkg::ST_ROW;
            end
          end
        end
        kms_pkg::ST_ROW: begin
          settle_r <= settle_r + 16'h0001;
          if (settled) begin
            pressed_matrix_r[row_idx_r] <= row_word_type'(row_sample);
            settle_r <= 16'h0000;
            if (row_idx_r == 3'(NR - 1)) begin
              row_r <= '0;
              state_r <= kms_pkg::ST_FILT;
            end else begin
              row_idx_r <= row_idx_r + 3'h1;
              row_r <= row_r << 1;
            end
          end
        end
        kms_pkg::ST_FILT: begin
          for (int r = 0; r < NR; r++) prev_matrix_r[r] <= pressed_matrix_r[r];
          if (accept) begin
            for (int r = 0; r < NR; r++) begin
              accepted_r[r] <= pressed_matrix_r[r];
              flat_r[r*NC +: NC] <= pressed_matrix_r[r][NC-1:0];
            end
            pend_r <= 1'b1;
          end
          state_r <= kms_pkg::ST_IDLE;
        end
        default: state_r <= kms_pkg::ST_IDLE;
      endcase
      if (state_r == kms_pkg::ST_MAP || (pend_r && deliver && state_r != kms_pkg::ST_FILT)) begin
        pend_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Report builder: walks flat matrix, maps up to six codes
  logic mapping_r;
  function automatic logic is_repeat(input logic [7:0] code, input logic [2:0] n,
                                     input logic [63:0] lst);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (3'(i) < n && lst[i*8 +: 8] == code) hit = 1'b1;
    end
    return hit;
  endfunction
  logic [63:0] rpt_flat;
  always_comb begin
    for (int i = 0; i < 8; i++) rpt_flat[i*8 +: 8] = rpt_list_r[i];
  end
  logic rpt_held_r;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mapping_r <= 1'b0;
      map_idx_r <= 5'h0_0;
      rep_r <= '0;
      upd_r <= 1'b0;
      rpt_held_r <= 1'b0;
      rpt_timer_r <= 32'h0000_0000;
    end else begin
      upd_r <= 1'b0;
      if (!mapping_r && pend_r && deliver) begin
        mapping_r <= 1'b1;
        map_idx_r <= 5'h0_0;
        rep_r.count <= 3'h0;
        rpt_held_r <= 1'b0;
      end else if (mapping_r) begin
        if (flat_r[map_idx_r] && rep_r.count != 3'(kms_pkg::REPORT_KEYS)) begin
          rep_r.codes[rep_r.count*8 +: 8] <= key_code_map[map_idx_r];
          rep_r.count <= rep_r.count + 3'h1;
          if (is_repeat(key_code_map[map_idx_r], rpt_cnt_r, rpt_flat)) rpt_held_r <= 1'b1;
        end
        if (map_idx_r == 5'(NK - 1)) begin
          mapping_r <= 1'b0;
          upd_r <= 1'b1;
          rpt_timer_r <= 32'h0000_0000;
        end else map_idx_r <= map_idx_r + 5'h01;
      end else if (rpt_en && rpt_held_r) begin
        rpt_timer_r <= rpt_timer_r + 32'h0000_0001;
        if (rpt_timer_r == 32'(REPEAT_CYC - 1)) begin
          rpt_timer_r <= 32'h0000_0000;
          upd_r <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stuck-key timer and wake polarity
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      now_r <= '0;
      last_press_timestamp_r <= '0;
      jammed_row_flags_r <= '0;
      sleep_r <= 1'b0;
      wake_low_r <= '0;
    end else begin
      now_r <= now_r + 40'h00_0000_0001;
      if (upd_r && rep_r.count != 3'h0) last_press_timestamp_r <= now_r;
      if (state_r == kms_pkg::ST_FILT) begin
        for (int r = 0; r < NR; r++) begin
          jammed_row_flags_r[r] <= equal_acc && pressed_matrix_r[r] != '0;
        end
      end
      if (stuck_en && !sleep_r && rep_r.count != 3'h0 && any_set &&
          (now_r - last_press_timestamp_r) > 40'(STUCK_CYC)) begin
        sleep_r <= 1'b1;
        wake_low_r <= jammed_row_flags_r;
      end else if (sleep_r && !any_set) begin
        sleep_r <= 1'b0;
        wake_low_r <= '0;
      end
    end
  end

  assign rdata_o = rdata_r;
  assign row_o = row_r;
  assign row_oe_o = row_r;
  assign update_o = upd_r;
  assign key_report_o = rep_r;
  assign deep_sleep_o = sleep_r;
  assign wake_low_o = wake_low_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_one_row;
    @(posedge clk_i) disable iff (!rst_b_i)
      state_r == kms_pkg::ST_ROW |-> $onehot(row_r);
  endproperty
  a_one_row: assert property (p_one_row) else $error("more than one row driven");
  property p_full_all;
    @(posedge clk_i) disable iff (!rst_b_i)
      state_r == kms_pkg::ST_FULL |-> row_r == '1;
  endproperty
  a_full_all: assert property (p_full_all) else $error("full scan not all rows");
  property p_no_rpt;
    @(posedge clk_i) disable iff (!rst_b_i)
      !$past(rpt_en) |-> rpt_timer_r == $past(rpt_timer_r) || rpt_timer_r == 32'h0000_0000;
  endproperty
  a_no_rpt: assert property (p_no_rpt) else $error("repeat timer ran disabled");
  property p_no_sleep;
    @(posedge clk_i) disable iff (!rst_b_i)
      !$past(stuck_en) && !$past(sleep_r) |-> !sleep_r;
  endproperty
  a_no_sleep: assert property (p_no_sleep) else $error("sleep while disabled");
  property p_cap6;
    @(posedge clk_i) disable iff (!rst_b_i)
      rep_r.count <= 3'(kms_pkg::REPORT_KEYS);
  endproperty
  a_cap6: assert property (p_cap6) else $error("report count above six");
  property p_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
      !deliver && !mapping_r |=> !mapping_r;
  endproperty
  a_hold: assert property (p_hold) else $error("entry released while held");
  property p_settle;
    @(posedge clk_i) disable iff (!rst_b_i)
      $rose(state_r == kms_pkg::ST_FULL) |-> state_r == kms_pkg::ST_FULL [*8];
  endproperty
  a_settle: assert property (p_settle) else $error("full scan left early");
  property p_wake;
    @(posedge clk_i) disable iff (!rst_b_i)
      $rose(sleep_r) |-> wake_low_r == $past(jammed_row_flags_r);
  endproperty
  a_wake: assert property (p_wake) else $error("wake polarity not switched");
endmodule

// ==== verification/kms_key_matrix.sv ====
`timescale 1ns/10ps
// Switch matrix: a closed key ties its row to its column
module kms_key_matrix (
  input wire logic [kms_pkg::NUM_ROWS-1:0] row_i,
  input wire logic [kms_pkg::NUM_ROWS-1:0] row_oe_i,
  input wire logic [29:0] keys_i,
  output logic [kms_pkg::NUM_COLS-1:0] col_o
);
  logic [kms_pkg::NUM_ROWS-1:0] row_lvl;
  // Released rows sit at the pull-down, so they never light a column
  assign row_lvl = row_i & row_oe_i;
  // Column pull-down wins unless a driven row reaches it through a key
  always_comb begin
    col_o = '0;
    for (int r = 0; r < kms_pkg::NUM_ROWS; r++) begin
      if (row_lvl[r]) begin
        col_o = col_o | keys_i[r*6 +: 6];
      end
    end
  end
endmodule

// ==== verification/kms_scanner_tb_top.sv ====
`timescale 1ns/10ps
module kms_scanner_tb_top;
  localparam int REP_C = 500;
  localparam int STUCK_C = 4000;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [kms_pkg::ADDR_W-1:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [31:0] d;
  logic [kms_pkg::NUM_COLS-1:0] col_i;
  logic [kms_pkg::NUM_ROWS-1:0] row_o, row_oe_o, wake_low_o;
  logic [kms_pkg::NUM_ROWS-1:0] row_prev = '0;
  logic update_o, deep_sleep_o;
  kms_pkg::kms_report_type key_report_o, rep_exp;
  kms_pkg::kms_report_type exp_q [$];
  logic [29:0] keys = '0;
  logic [7:0] kmap [30];
  int num_errors = 0, total_checks = 0, cyc = 0, last_upd = 0, rep_n = 0, run = 0;
  bit rep_mode = 1'b0;

  always #10 clk_i = ~clk_i;

  kms_scanner #(.REPEAT_CYC(REP_C), .STUCK_CYC(STUCK_C)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .col_i(col_i), .row_o(row_o), .row_oe_o(row_oe_o),
    .update_o(update_o), .key_report_o(key_report_o), .deep_sleep_o(deep_sleep_o),
    .wake_low_o(wake_low_o));
  kms_key_matrix far_side (.row_i(row_o), .row_oe_i(row_oe_o), .keys_i(keys), .col_o(col_i));

  ////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Register port: strobes last one cycle, read data stand the cycle after
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Expected report: row-major order, only the first six codes
  function automatic kms_pkg::kms_report_type mk(input logic [29:0] k);
    kms_pkg::kms_report_type e;
    e = '0;
    for (int i = 0; i < 30; i++) begin
      if (k[i] && e.count < 3'd6) begin
        e.codes[e.count*8 +: 8] = kmap[i];
        e.count = e.count + 3'd1;
      end
    end
    return e;
  endfunction

  // Codes past the count are stale by design, so they are masked off
  task automatic cmp_rep(input kms_pkg::kms_report_type e);
    logic [47:0] m;
    m = '0;
    for (int i = 0; i < 6; i++) if (i < e.count) m[i*8 +: 8] = 8'hff;
    chk({key_report_o.count, key_report_o.codes & m}, {e.count, e.codes & m});
  endtask

  // One scan; optionally peek at the state mid-scan, then wait for idle
  task automatic scan(input bit look, input logic [4:0] st);
    wr(kms_pkg::SCAN_GO_OFS, 32'h0000_0001);
    repeat (1500) @(posedge clk_i);
    if (look) begin
      rd(kms_pkg::STATUS_OFS);
      chk(d[4:0], st);
    end
    for (int i = 0; i < 100; i++) begin
      rd(kms_pkg::STATUS_OFS);
      if (d[4:0] === kms_pkg::ST_IDLE) break;
      repeat (100) @(posedge clk_i);
    end
    // Idle comes before the 30-cycle map walk ends, so let the report out
    repeat (40) @(posedge clk_i);
  endtask

  // New key state; the note goes in only before the scan that must report
  task automatic step(input logic [29:0] k, input int n);
    @(posedge clk_i);
    keys <= k;
    for (int i = 0; i < n; i++) begin
      if (i == n - 1) exp_q.push_back(mk(k));
      scan(1'b0, 5'h00);
    end
    chk(exp_q.size(), 0);
  endtask

  ////////////////////////////////////////
  // Result watcher: outside repeat mode each update takes the oldest note
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (update_o === 1'b1) begin
      last_upd <= cyc;
      if (rep_mode) begin
        rep_n++;
        cmp_rep(rep_exp);
      end else if (exp_q.size() == 0) begin
        chk(1, 0);
      end else begin
        cmp_rep(exp_q.pop_front());
      end
    end
  end

  // Row drive: all rows or one row, each held long enough to settle
  always @(posedge clk_i) begin
    row_prev <= row_o;
    run <= (row_o === row_prev) ? run + 1 : 0;
    if (row_o !== row_prev) begin
      chk(row_oe_o, row_o);
      chk($onehot0(row_o) || row_o === 5'h1f, 1);
      if (row_prev !== 5'h00) chk(run >= kms_pkg::SETTLE_CYC - 2, 1);
    end
  end

  // Hang guard, only about a seventh above the planned run length
  always @(posedge clk_i) begin
    if (cyc > 90000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    void'($urandom(82306));
    for (int i = 0; i < 30; i++) kmap[i] = 8'($urandom_range(255, 1));
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(kms_pkg::CTRL_OFS);
    chk(d, 32'h0000_0001);
    rd(4'hf);
    chk(d, 32'h0000_0000);
    for (int i = 0; i < 30; i++) begin
      wr(kms_pkg::MAP_ADDR_OFS, i);
      wr(kms_pkg::MAP_DATA_OFS, 32'(kmap[i]));
    end
    scan(1'b1, kms_pkg::ST_IDLE);
    step(30'h0000_8000, 2);
    rd(kms_pkg::STATUS_OFS);
    chk(d[15:10], 6'h08);
    step(30'h2220_4211, 2);
    repeat (STUCK_C + 100) @(posedge clk_i);
    chk(deep_sleep_o, 0);
    step(30'h0000_0000, 2);
    scan(1'b1, kms_pkg::ST_ROW);
    // Held delivery: entry waits until delivery is set again
    wr(kms_pkg::CTRL_OFS, 32'h0000_0000);
    @(posedge clk_i);
    keys <= 30'h0000_0001;
    repeat (2) scan(1'b0, 5'h00);
    rd(kms_pkg::STATUS_OFS);
    chk(d[8], 1);
    exp_q.push_back(mk(30'h0000_0001));
    wr(kms_pkg::CTRL_OFS, 32'h0000_0001);
    // Release plus the 30-cycle map walk
    repeat (40) @(posedge clk_i);
    chk(exp_q.size(), 0);
    // Repeat list goes in before the key is mapped, so the held key is known
    wr(kms_pkg::RPT_CNT_OFS, 32'h0000_0001);
    wr(kms_pkg::RPT_LIST_OFS, 32'(kmap[29]));
    wr(kms_pkg::CTRL_OFS, 32'h0000_0009);
    step(30'h2000_0000, 1);
    wr(kms_pkg::CTRL_OFS, 32'h0000_0001);
    // Agreeing scan, no change: row 4 gets its jam flag, no update
    scan(1'b0, 5'h00);
    // Auto-repeat on the held key
    rep_exp = mk(30'h2000_0000);
    rep_mode = 1'b1;
    wr(kms_pkg::CTRL_OFS, 32'h0000_0003);
    repeat (4 * REP_C) @(posedge clk_i);
    wr(kms_pkg::CTRL_OFS, 32'h0000_0001);
    rep_mode = 1'b0;
    chk(rep_n >= 3 && rep_n <= 5, 1);
    // Stuck key: sleep only past the timeout, wake polarity flips on row 4
    wr(kms_pkg::CTRL_OFS, 32'h0000_0005);
    while (cyc < last_upd + STUCK_C - 20) @(posedge clk_i);
    chk(deep_sleep_o, 0);
    repeat (40) @(posedge clk_i);
    chk({deep_sleep_o, wake_low_o}, {1'b1, 5'h10});
    rd(kms_pkg::STATUS_OFS);
    chk(d[20:16], 5'h10);
    wrap_up();
  end
endmodule
